// *** core/mci_apb_port.sv ***
// Purpose: APB slave front end; one setup cycle and one access cycle per transfer
// Assumes: master keeps the request stable until pready is seen high
// Notes: read data and error are captured at the setup edge
`timescale 1ns/1ps

module mci_apb_port
	import mci_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`MCI_AW-1:0] paddr,
	input wire logic [`MCI_DW-1:0] rdata_sel,
	output logic pready,
	output logic pslverr,
	output logic [`MCI_DW-1:0] prdata,
	output logic wr_stb,
	output logic rd_stb
);

	mci_apb_st_t st_reg;
	mci_apb_st_t st_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic [`MCI_DW-1:0] prdata_reg;
	logic [`MCI_DW-1:0] prdata_next;
	logic commit;

	// transfer completes at the edge where the access cycle sees pready
	assign commit = (st_reg == MCI_ST_ACC) && psel && penable && pready_reg;
	assign wr_stb = commit && pwrite && !pslverr_reg;
	assign rd_stb = commit && !pwrite && !pslverr_reg;

	always_comb begin
		st_next = st_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		prdata_next = prdata_reg;
		unique case (st_reg)
			MCI_ST_IDLE: begin
				if (psel && !penable) begin
					st_next = MCI_ST_ACC;
					pready_next = 1'b1;
					pslverr_next = !mci_mapped(paddr);
					prdata_next = (pwrite || !mci_mapped(paddr)) ? `MCI_RST_DATA : rdata_sel;
				end
			end
			MCI_ST_ACC: begin
				st_next = MCI_ST_IDLE;
			end
			default: begin
				st_next = MCI_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= MCI_ST_IDLE;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= `MCI_RST_DATA;
		end else begin
			st_reg <= st_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;

endmodule : mci_apb_port

// *** core/mci_defines.svh ***
// Purpose: register offsets, field positions and reset values of the command-done interrupt block
// Assumes: APB with 8-bit byte address, 32-bit data
// Notes: every register takes one aligned word
`ifndef MCI_DEFINES_SVH
`define MCI_DEFINES_SVH

`define MCI_AW 8
`define MCI_DW 32
`define MCI_NSLOT 2
`define MCI_NEVT 3

`define MCI_OFS_RAW 8'h00
`define MCI_OFS_MASKED 8'h04
`define MCI_OFS_EN_SET 8'h08
`define MCI_OFS_EN_CLR 8'h0c
`define MCI_OFS_GO 8'h10
`define MCI_OFS_EVT_STAT 8'h14
`define MCI_OFS_EVT_MASK 8'h18

`define MCI_EVT_DONE0 0
`define MCI_EVT_DONE1 1
`define MCI_EVT_GO_REFUSED 2

`define MCI_RST_SLOT 2'h0
`define MCI_RST_EVT 3'h0
`define MCI_RST_DATA 32'h0000_0000

`endif

// *** core/mci_pkg.sv ***
// Purpose: shared types and decode helpers of the command-done interrupt block
// Assumes: constants come from mci_defines.svh
// Notes: none
`include "mci_defines.svh"

package mci_pkg;

	typedef enum logic [1:0] {
		MCI_ST_IDLE = 2'b01,
		MCI_ST_ACC = 2'b10
	} mci_apb_st_t;

	function automatic logic mci_mapped(input logic [`MCI_AW-1:0] a);
		mci_mapped = (a == `MCI_OFS_RAW) || (a == `MCI_OFS_MASKED) ||
			(a == `MCI_OFS_EN_SET) || (a == `MCI_OFS_EN_CLR) ||
			(a == `MCI_OFS_GO) || (a == `MCI_OFS_EVT_STAT) ||
			(a == `MCI_OFS_EVT_MASK);
	endfunction : mci_mapped

endpackage : mci_pkg

// *** core/mci_sticky.sv ***
// Purpose: bank of sticky flags, set by hardware and cleared by software
// Assumes: set and clr are single-cycle terms in the pclk domain
// Notes: a set in the same cycle as a clear wins
`timescale 1ns/1ps

module mci_sticky #(
	parameter int W = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] q
);

	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	always_comb begin
		q_next = (q_reg & ~clr) | set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign q = q_reg;

endmodule : mci_sticky

// *** core/mci_top.sv ***
// Purpose: command-complete interrupt status, mask and go bits of two user access slots
// Assumes: slot_done pulses for one pclk cycle when the serial engine finishes a slot access
// Notes: all outputs come from flip-flops
// Functional notes
// - Slot 1 completion sets raw completion flag bit 1.
// - Slot 0 completion sets raw completion flag bit 0.
// - Writing 1 to a raw flag bit clears it, writing 0 leaves it.
// - A masked bit reads 1 only when the raw flag and the slot enable are both 1.
// - Writing 1 to a masked bit clears that pending interrupt, writing 0 does nothing.
// - Writing 1 to an enable-set bit enables that slot's completion interrupt.
// - An enable bit of 0 disables the slot interrupt and the enable state reads back.
// - Writing 0 to an enable-set bit leaves the enable unchanged.
// - Writing 1 to an enable-clear bit disables the slot interrupt, 0 does nothing.
// - A slot go bit self-clears at the moment its completion event is raised.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps

module mci_top
	import mci_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`MCI_AW-1:0] paddr,
	input wire logic [`MCI_DW-1:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [`MCI_DW-1:0] prdata,
	input wire logic mdio_enabled,
	input wire logic [`MCI_NSLOT-1:0] slot_done,
	output logic [`MCI_NSLOT-1:0] slot_go,
	output logic cmd_done_irq,
	output logic evt_irq
);

	logic wr_stb;
	logic rd_stb;
	logic [`MCI_DW-1:0] rdata_sel;
	logic [`MCI_NSLOT-1:0] wdat;
	logic wr_raw;
	logic wr_masked;
	logic wr_en_set;
	logic wr_en_clr;
	logic wr_go;
	logic wr_evt_mask;
	logic rd_evt;

	logic [`MCI_NSLOT-1:0] raw_q;
	logic [`MCI_NSLOT-1:0] raw_set;
	logic [`MCI_NSLOT-1:0] raw_clr;
	logic [`MCI_NSLOT-1:0] raw_next;
	logic [`MCI_NSLOT-1:0] masked;
	logic [`MCI_NSLOT-1:0] en_reg;
	logic [`MCI_NSLOT-1:0] en_next;
	logic [`MCI_NSLOT-1:0] go_reg;
	logic [`MCI_NSLOT-1:0] go_next;
	logic [`MCI_NSLOT-1:0] go_req;
	logic [`MCI_NSLOT-1:0] done_hit;

	logic [`MCI_NEVT-1:0] evt_q;
	logic [`MCI_NEVT-1:0] evt_set;
	logic [`MCI_NEVT-1:0] evt_clr;
	logic [`MCI_NEVT-1:0] evt_next;
	logic [`MCI_NEVT-1:0] evt_mask_reg;
	logic [`MCI_NEVT-1:0] evt_mask_next;
	logic cmd_done_irq_reg;
	logic cmd_done_irq_next;
	logic evt_irq_reg;
	logic evt_irq_next;

	function automatic logic [`MCI_DW-1:0] zext_slot(input logic [`MCI_NSLOT-1:0] v);
		zext_slot = {{(`MCI_DW-`MCI_NSLOT){1'b0}}, v};
	endfunction : zext_slot

	function automatic logic [`MCI_DW-1:0] zext_evt(input logic [`MCI_NEVT-1:0] v);
		zext_evt = {{(`MCI_DW-`MCI_NEVT){1'b0}}, v};
	endfunction : zext_evt

	mci_apb_port u_port (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.rdata_sel(rdata_sel),
		.pready(pready),
		.pslverr(pslverr),
		.prdata(prdata),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb)
	);

	// write strobes per register, valid at the committing edge only
	assign wdat = pwdata[`MCI_NSLOT-1:0];
	assign wr_raw = wr_stb && (paddr == `MCI_OFS_RAW);
	assign wr_masked = wr_stb && (paddr == `MCI_OFS_MASKED);
	assign wr_en_set = wr_stb && (paddr == `MCI_OFS_EN_SET);
	assign wr_en_clr = wr_stb && (paddr == `MCI_OFS_EN_CLR);
	assign wr_go = wr_stb && (paddr == `MCI_OFS_GO);
	assign wr_evt_mask = wr_stb && (paddr == `MCI_OFS_EVT_MASK);
	assign rd_evt = rd_stb && (paddr == `MCI_OFS_EVT_STAT);

	// masked view of the raw flags
	assign masked = raw_q & en_reg;

	always_comb begin
		rdata_sel = `MCI_RST_DATA;
		unique case (paddr)
			`MCI_OFS_RAW: rdata_sel = zext_slot(raw_q);
			`MCI_OFS_MASKED: rdata_sel = zext_slot(masked);
			`MCI_OFS_EN_SET: rdata_sel = zext_slot(en_reg);
			`MCI_OFS_EN_CLR: rdata_sel = zext_slot(en_reg);
			`MCI_OFS_GO: rdata_sel = zext_slot(go_reg);
			`MCI_OFS_EVT_STAT: rdata_sel = zext_evt(evt_q);
			`MCI_OFS_EVT_MASK: rdata_sel = zext_evt(evt_mask_reg);
			default: rdata_sel = `MCI_RST_DATA;
		endcase
	end

	// completion counts only for a slot with an access in flight
	assign done_hit = slot_done & go_reg;

	always_comb begin
		raw_set = done_hit;
		// write-one clears, masked clear only where pending
		raw_clr = ({`MCI_NSLOT{wr_raw}} & wdat) | ({`MCI_NSLOT{wr_masked}} & wdat & en_reg);
		raw_next = (raw_q & ~raw_clr) | raw_set;
	end

	mci_sticky #(
		.W(`MCI_NSLOT)
	) u_raw (
		.pclk(pclk),
		.presetn(presetn),
		.set(raw_set),
		.clr(raw_clr),
		.q(raw_q)
	);

	always_comb begin
		en_next = en_reg | ({`MCI_NSLOT{wr_en_set}} & wdat);
		en_next = en_next & ~({`MCI_NSLOT{wr_en_clr}} & wdat);
		// go accepted only while idle and engine enabled
		go_req = {`MCI_NSLOT{wr_go && mdio_enabled}} & wdat & ~go_reg;
		go_next = (go_reg & ~done_hit) | go_req;
		evt_mask_next = wr_evt_mask ? pwdata[`MCI_NEVT-1:0] : evt_mask_reg;
	end

	always_comb begin
		evt_set = '0;
		evt_set[`MCI_EVT_DONE0] = done_hit[0];
		evt_set[`MCI_EVT_DONE1] = done_hit[1];
		evt_set[`MCI_EVT_GO_REFUSED] = wr_go && (wdat != '0) && !mdio_enabled;
		// read clears only the bits that the read returned
		evt_clr = rd_evt ? prdata[`MCI_NEVT-1:0] : '0;
		evt_next = (evt_q & ~evt_clr) | evt_set;
	end

	mci_sticky #(
		.W(`MCI_NEVT)
	) u_evt (
		.pclk(pclk),
		.presetn(presetn),
		.set(evt_set),
		.clr(evt_clr),
		.q(evt_q)
	);

	always_comb begin
		// OR of masked bits, disabled slots drop out
		cmd_done_irq_next = |(raw_next & en_next);
		evt_irq_next = |(evt_next & evt_mask_next);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= `MCI_RST_SLOT;
			go_reg <= `MCI_RST_SLOT;
			evt_mask_reg <= `MCI_RST_EVT;
			cmd_done_irq_reg <= 1'b0;
			evt_irq_reg <= 1'b0;
		end else begin
			en_reg <= en_next;
			go_reg <= go_next;
			evt_mask_reg <= evt_mask_next;
			cmd_done_irq_reg <= cmd_done_irq_next;
			evt_irq_reg <= evt_irq_next;
		end
	end

	assign slot_go = go_reg;
	assign cmd_done_irq = cmd_done_irq_reg;
	assign evt_irq = evt_irq_reg;

	// slot 1 done sets raw bit 1
	AST_RAW1_SET: assert property (@(posedge pclk) disable iff (!presetn)
		slot_done[1] && go_reg[1] |=> raw_q[1])
		else $error("raw bit 1 not set after slot 1 completion");

	// slot 0 done sets raw bit 0
	AST_RAW0_SET: assert property (@(posedge pclk) disable iff (!presetn)
		slot_done[0] && go_reg[0] |=> raw_q[0])
		else $error("raw bit 0 not set after slot 0 completion");

	AST_RAW_W1C: assert property (@(posedge pclk) disable iff (!presetn)
		wr_raw && wdat[0] && !done_hit[0] |=> !raw_q[0])
		else $error("raw bit 0 survived a write of one");

	AST_RAW_W0_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		wr_raw && !wdat[1] && raw_q[1] |=> raw_q[1])
		else $error("raw bit 1 lost on a write of zero");

	AST_MASKED_READ: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr == `MCI_OFS_MASKED && pready == 1'b0
		|=> prdata[`MCI_NSLOT-1:0] == $past(raw_q & en_reg))
		else $error("masked readback differs from raw and enable");

	AST_MASKED_W1C: assert property (@(posedge pclk) disable iff (!presetn)
		wr_masked && wdat[1] && en_reg[1] && !done_hit[1] |=> !raw_q[1])
		else $error("pending bit 1 survived masked clear");

	AST_EN_SET: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en_set && wdat[0] |=> en_reg[0])
		else $error("enable bit 0 not set");

	AST_EN_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en_set && !wdat[1] |=> en_reg[1] == $past(en_reg[1]))
		else $error("enable bit 1 changed on a write of zero");

	AST_EN_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en_clr && wdat[1] |=> !en_reg[1])
		else $error("enable bit 1 not cleared");

	// with both slots disabled the interrupt stays low
	AST_DIS_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		en_reg == 2'h0 |-> !cmd_done_irq)
		else $error("interrupt high with both slots disabled");

	AST_GO_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		slot_done[0] && go_reg[0] |=> !slot_go[0] && raw_q[0])
		else $error("go bit 0 not cleared together with its event");

	// output equals OR of masked bits
	AST_IRQ_OR: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_done_irq == |(raw_q & en_reg))
		else $error("interrupt output differs from OR of masked bits");

	AST_RAW1_W1C: assert property (@(posedge pclk) disable iff (!presetn)
		wr_raw && wdat[1] && !done_hit[1] |=> !raw_q[1])
		else $error("raw bit 1 survived a write of one");

	AST_RAW0_W0_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		wr_raw && !wdat[0] && raw_q[0] |=> raw_q[0])
		else $error("raw bit 0 lost on a write of zero");

	AST_MASKED0_W1C: assert property (@(posedge pclk) disable iff (!presetn)
		wr_masked && wdat[0] && en_reg[0] && !done_hit[0] |=> !raw_q[0])
		else $error("pending bit 0 survived masked clear");

	AST_MASKED_W0_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		wr_masked && !wdat[0] && raw_q[0] |=> raw_q[0])
		else $error("raw bit 0 lost on a masked write of zero");

	AST_EN1_SET: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en_set && wdat[1] |=> en_reg[1])
		else $error("enable bit 1 not set");

	AST_EN0_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en_clr && wdat[0] |=> !en_reg[0])
		else $error("enable bit 0 not cleared");

	AST_EN_CLR_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en_clr && !wdat[0] |=> en_reg[0] == $past(en_reg[0]))
		else $error("enable bit 0 changed on a clear write of zero");

	AST_EN_READ: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr == `MCI_OFS_EN_SET && pready == 1'b0
		|=> prdata[`MCI_NSLOT-1:0] == $past(en_reg))
		else $error("enable readback differs from enable state");

	AST_GO1_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		slot_done[1] && go_reg[1] |=> !slot_go[1] && raw_q[1])
		else $error("go bit 1 not cleared together with its event");

	AST_DONE0_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		slot_done[0] && !go_reg[0] && !raw_q[0] |=> !raw_q[0])
		else $error("raw bit 0 set by a completion with no access in flight");

endmodule : mci_top

// *** dv/tb_top.sv ***
// Purpose: self-checking bench of the command-done interrupt block
// Assumes: one access cycle per apb transfer, slot_done as one-cycle pulses
// Notes: pready and read data are taken at the rising edge that ends the access
`timescale 1ns/1ps
`include "mci_defines.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end

module tb_top
	import mci_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, mdio_enabled;
	logic [`MCI_AW-1:0] paddr;
	logic [`MCI_DW-1:0] pwdata, prdata;
	logic pready, pslverr, cmd_done_irq, evt_irq;
	logic [`MCI_NSLOT-1:0] slot_done, slot_go;
	int fails = 0;
	int n_compared = 0;

	mci_top i_mci_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .mdio_enabled(mdio_enabled),
		.slot_done(slot_done), .slot_go(slot_go), .cmd_done_irq(cmd_done_irq),
		.evt_irq(evt_irq));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	// one apb transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// the wait ends when pready is seen high; the watchdog ends it otherwise
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, d, rd, err);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee = 1'b0);
		logic [31:0] rv;
		logic err;
		apb(1'b0, a, 32'h0000_0000, rv, err);
		`CHK(rv, e)
		`CHK(err, ee)
	endtask : rd

	task automatic pulse(input int i);
		@(posedge pclk);
		slot_done <= 2'h1 << i;
		@(posedge pclk);
		slot_done <= 2'h0;
	endtask : pulse

	// request an access on slot i and let the serial engine finish it
	task automatic go_done(input int i);
		wr(`MCI_OFS_GO, 32'h1 << i);
		@(negedge pclk);
		`CHK(slot_go[i], 1'b1)
		repeat (3) @(posedge pclk);
		pulse(i);
		@(negedge pclk);
		`CHK(slot_go[i], 1'b0)
	endtask : go_done

	task automatic t_reset();
		rd(`MCI_OFS_RAW, 32'h0);
		rd(`MCI_OFS_MASKED, 32'h0);
		rd(`MCI_OFS_EN_SET, 32'h0);
		rd(`MCI_OFS_GO, 32'h0);
		rd(8'h1c, 32'h0, 1'b1);
		rd(`MCI_OFS_EVT_STAT, 32'h0);
		rd(`MCI_OFS_EVT_MASK, 32'h0);
		`CHK(cmd_done_irq, 1'b0)
		`CHK(evt_irq, 1'b0)
		$display("test reset done");
	endtask : t_reset

	// reset in mid-run with flags, enables and a go bit standing
	task automatic t_midreset();
		wr(`MCI_OFS_EN_SET, 32'h3);
		go_done(0);
		wr(`MCI_OFS_GO, 32'h2);
		@(negedge pclk);
		`CHK(cmd_done_irq, 1'b1)
		`CHK(slot_go, 2'h2)
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		$display("test mid reset done");
	endtask : t_midreset

	task automatic t_done();
		pulse(0);
		rd(`MCI_OFS_RAW, 32'h0);
		go_done(1);
		rd(`MCI_OFS_RAW, 32'h2);
		go_done(0);
		rd(`MCI_OFS_RAW, 32'h3);
		rd(`MCI_OFS_MASKED, 32'h0);
		`CHK(cmd_done_irq, 1'b0)
		$display("test done flags done");
	endtask : t_done

	task automatic t_raw_clear();
		wr(`MCI_OFS_RAW, 32'h0);
		rd(`MCI_OFS_RAW, 32'h3);
		wr(`MCI_OFS_RAW, 32'h1);
		rd(`MCI_OFS_RAW, 32'h2);
		wr(8'h1c, 32'h2);
		rd(`MCI_OFS_RAW, 32'h2);
		wr(`MCI_OFS_RAW, 32'h2);
		rd(`MCI_OFS_RAW, 32'h0);
		$display("test raw clear done");
	endtask : t_raw_clear

	task automatic t_enable();
		wr(`MCI_OFS_EN_SET, 32'h1);
		rd(`MCI_OFS_EN_SET, 32'h1);
		wr(`MCI_OFS_EN_SET, 32'h0);
		rd(`MCI_OFS_EN_SET, 32'h1);
		go_done(1);
		go_done(0);
		rd(`MCI_OFS_MASKED, 32'h1);
		`CHK(cmd_done_irq, 1'b1)
		wr(`MCI_OFS_MASKED, 32'h0);
		rd(`MCI_OFS_MASKED, 32'h1);
		wr(`MCI_OFS_MASKED, 32'h1);
		rd(`MCI_OFS_MASKED, 32'h0);
		rd(`MCI_OFS_RAW, 32'h2);
		`CHK(cmd_done_irq, 1'b0)
		wr(`MCI_OFS_EN_SET, 32'h2);
		rd(`MCI_OFS_MASKED, 32'h2);
		`CHK(cmd_done_irq, 1'b1)
		wr(`MCI_OFS_EN_CLR, 32'h0);
		rd(`MCI_OFS_EN_SET, 32'h3);
		wr(`MCI_OFS_EN_CLR, 32'h2);
		rd(`MCI_OFS_EN_CLR, 32'h1);
		rd(`MCI_OFS_MASKED, 32'h0);
		`CHK(cmd_done_irq, 1'b0)
		wr(`MCI_OFS_RAW, 32'h2);
		$display("test enable done");
	endtask : t_enable

	// event status: read clears, go refused while the serial engine is off
	task automatic t_evt();
		rd(`MCI_OFS_EVT_STAT, 32'h3);
		rd(`MCI_OFS_EVT_STAT, 32'h0);
		wr(`MCI_OFS_EVT_MASK, 32'h4);
		mdio_enabled <= 1'b0;
		wr(`MCI_OFS_GO, 32'h1);
		@(negedge pclk);
		`CHK(slot_go, 2'h0)
		`CHK(evt_irq, 1'b1)
		rd(`MCI_OFS_EVT_STAT, 32'h4);
		@(negedge pclk);
		`CHK(evt_irq, 1'b0)
		mdio_enabled <= 1'b1;
		$display("test event done");
	endtask : t_evt

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		mdio_enabled = 1'b1;
		slot_done = 2'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_done();
		t_raw_clear();
		t_enable();
		t_evt();
		t_midreset();
		finish_test();
	end

	initial begin
		#(3000 * 50);
		fails++;
		finish_test();
	end
endmodule : tb_top
